// ---- rpmc_pkg.sv ----
package rpmc_pkg;

    // Clock relations: one machine cycle is twelve oscillator periods
    localparam int OSC_PER_MACHINE = 12;
    localparam int RESET_MACHINE_CYCLES = 2;
    localparam int RESET_MIN_CYCLES = OSC_PER_MACHINE * RESET_MACHINE_CYCLES;
    localparam int VERIFY_MACHINE_CYCLES = 4;
    localparam int VERIFY_DELAY_CYCLES = OSC_PER_MACHINE * VERIFY_MACHINE_CYCLES;

    // Serial programming entry code
    localparam int ENTRY_CODE_BITS = 10;
    localparam logic [ENTRY_CODE_BITS-1:0] ENTRY_CODE_DEFAULT = 10'h2B5; // Arbitrary value

    // Programming address layout
    localparam int ADDR_BITS = 11;
    localparam int ADDR_HI_BITS = 3;
    localparam int ADDR_LO_BITS = 8;
    localparam int LOW_SETTLE_CYCLES = 13;

    // Power control register fields and reset values
    localparam int POWER_CONTROL_REGISTER_IDLE_BIT = 0;
    localparam int POWER_CONTROL_REGISTER_PDOWN_BIT = 1;
    localparam logic [7:0] POWER_CONTROL_REGISTER_RESET = 8'h00;
    localparam logic [7:0] PORT_LATCH_RESET = 8'hFF;

    // Interrupt sources, index 0 has the highest priority
    localparam int IRQ_EXT_A = 0;
    localparam int IRQ_TIMER0 = 1;
    localparam int IRQ_EXT_B = 2;
    localparam int IRQ_WDOG = 3;
    localparam int IRQ_SERIAL = 4;
    localparam int NUM_IRQ = 5;

    // Fixed program memory vectors
    localparam logic [ADDR_BITS-1:0] VEC_RESET = 11'h000;
    localparam logic [ADDR_BITS-1:0] VEC_EXT_A = 11'h003;
    localparam logic [ADDR_BITS-1:0] VEC_TIMER0 = 11'h00B;
    localparam logic [ADDR_BITS-1:0] VEC_EXT_B = 11'h013;
    localparam logic [ADDR_BITS-1:0] VEC_WDOG = 11'h01B;
    localparam logic [ADDR_BITS-1:0] VEC_SERIAL = 11'h023;

    // Operating modes
    typedef enum logic [2:0] {
        MODE_RESET = 3'b000,
        MODE_RUN = 3'b001,
        MODE_IDLE = 3'b010,
        MODE_PDOWN = 3'b011,
        MODE_PROG = 3'b100
    } mode_t;

    // Events from the reset pin monitor
    typedef struct packed {
        logic sys_reset;
        logic enter_prog;
    } reset_event_t;

    // Synchronised programming pins
    typedef struct packed {
        logic address_byte_select;
        logic [7:0] port3;
        logic prog_pulse_n;
        logic vpp_high;
        logic [7:0] port1;
    } pin_bus_t;

endpackage

// ---- reset_pin_monitor.sv ----
`timescale 1ns/1ps

module reset_pin_monitor
    import rpmc_pkg::*;
#(
    parameter logic [ENTRY_CODE_BITS-1:0] ENTRY_CODE = ENTRY_CODE_DEFAULT
)
(
    input wire logic i_ref_clk, // Oscillator input clock
    input wire logic i_rst_n, // Synchronous reset, active low
    input wire logic i_reset_pin, // Raw reset pin level
    output reset_event_t o_event // Reset level and entry pulse
);

    localparam int CNT_W = $clog2(RESET_MIN_CYCLES + 1);
    localparam int BITS_W = $clog2(ENTRY_CODE_BITS + 1);

    logic pin_meta; // First synchroniser stage
    logic pin_sync; // Second synchroniser stage
    logic [CNT_W-1:0] high_cnt; // Consecutive high samples
    logic [CNT_W-1:0] next_high_cnt;
    logic [ENTRY_CODE_BITS-1:0] shift; // Last samples, newest at the top
    logic [ENTRY_CODE_BITS-1:0] next_shift;
    logic [BITS_W-1:0] bit_cnt; // Samples taken since arming
    logic [BITS_W-1:0] next_bit_cnt;
    logic armed; // Entry code may still be received
    logic next_armed;
    reset_event_t next_event;

    // Two-stage pin synchroniser
    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rst_n)
        begin
            pin_meta <= 1'b0;
            pin_sync <= 1'b0;
        end
        else
        begin
            pin_meta <= i_reset_pin;
            pin_sync <= pin_meta;
        end
    end

    // Reset detector and entry code shifter
    always_comb
    begin
        next_high_cnt = '0;
        if (pin_sync)
        begin
            if (high_cnt == CNT_W'(RESET_MIN_CYCLES))
                next_high_cnt = high_cnt;
            else
                next_high_cnt = high_cnt + 1'b1;
        end
        next_event.sys_reset = (next_high_cnt == CNT_W'(RESET_MIN_CYCLES));
        next_event.enter_prog = 1'b0;
        next_armed = armed;
        next_shift = shift;
        next_bit_cnt = bit_cnt;
        if (o_event.sys_reset)
        begin
            // Arm after every reset, clear history
            next_armed = 1'b1;
            next_shift = '0;
            next_bit_cnt = '0;
        end
        else if (armed)
        begin
            // One bit per clock, first bit ends up at the bottom
            next_shift = {pin_sync, shift[ENTRY_CODE_BITS-1:1]};
            if (bit_cnt != BITS_W'(ENTRY_CODE_BITS))
                next_bit_cnt = bit_cnt + 1'b1;
            if (next_bit_cnt == BITS_W'(ENTRY_CODE_BITS) && next_shift == ENTRY_CODE)
            begin
                next_event.enter_prog = 1'b1;
                next_armed = 1'b0;
            end
        end
    end

    // State registers
    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rst_n)
        begin
            high_cnt <= '0;
            shift <= '0;
            bit_cnt <= '0;
            armed <= 1'b0;
            o_event <= '0;
        end
        else
        begin
            high_cnt <= next_high_cnt;
            shift <= next_shift;
            bit_cnt <= next_bit_cnt;
            armed <= next_armed;
            o_event <= next_event;
        end
    end

    default clocking mon_cb @(posedge i_ref_clk);
    endclocking
    default disable iff (!i_rst_n);

    reset_count_a: assert property (pin_sync && high_cnt == CNT_W'(RESET_MIN_CYCLES - 1)
        |=> o_event.sys_reset) else $error("reset not raised after full count");
    reset_early_a: assert property (o_event.sys_reset |-> $past(pin_sync))
        else $error("reset raised without high pin");
    entry_match_a: assert property (o_event.enter_prog |-> shift == ENTRY_CODE)
        else $error("entry taken on wrong code");

endmodule

// ---- reset_power_mode_control.sv ----
`timescale 1ns/1ps

// Behaviour
// - Reset after pin high 24 oscillator periods
// - Ten-bit code after reset enters programming
// - Sample bits at clock high, pin low after
// - Eleven-bit address multiplexed on second port
// - Select high takes three bits, low byte
// - Verify drives data port, programming reads it
// - Internal clock divided by two
// - Idle halts processor after the instruction
// - Idle preserves processor and register state
// - Interrupt or reset ends idle
// - Power-down stops oscillator after the instruction
// - Only reset leaves power-down
// - Mode bits live in power control register
// - Fixed reset and interrupt vector addresses
// - Fixed single-level interrupt priority order
module reset_power_mode_control
    import rpmc_pkg::*;
#(
    parameter logic [ENTRY_CODE_BITS-1:0] ENTRY_CODE = ENTRY_CODE_DEFAULT
)
(
    input wire logic i_ref_clk, // Oscillator input clock
    input wire logic i_rst_n, // Synchronous reset, active low
    input wire logic i_reset_pin, // Reset pin, also serial code input
    input wire logic i_address_select_pin, // Address byte select pin
    input wire logic [7:0] i_port3, // Second port, address input
    input wire logic i_prog_pulse_n, // Program pulse pin, low pulses write
    input wire logic i_vpp_high, // Programming voltage present
    input wire logic [7:0] i_port1, // First data port pin levels
    input wire logic [7:0] i_eprom_rdata, // Memory read data
    input wire logic i_power_control_register_wr, // Processor writes power control
    input wire logic [7:0] i_power_control_register_wdata, // Power control write data
    input wire logic i_instr_done, // Current instruction completes
    input wire logic [NUM_IRQ-1:0] i_irq_pending, // Interrupt flags
    input wire logic [NUM_IRQ-1:0] i_irq_enable, // Interrupt enables
    input wire logic i_port_wr, // Processor writes port latch
    input wire logic [7:0] i_port_wdata, // Port latch write data
    output logic o_machine_clk, // Divided internal clock
    output logic o_cpu_reset, // Processor held in reset
    output logic o_cpu_run, // Processor executes
    output logic o_periph_run, // Peripherals clocked
    output logic o_osc_enable, // Oscillator running
    output logic o_prog_state, // Programming state active
    output logic [7:0] o_power_control_register, // Power control contents
    output logic [ADDR_BITS-1:0] o_vector_addr, // Fetch start address
    output logic o_vector_valid, // Vector taken this cycle
    output logic [ADDR_BITS-1:0] o_eprom_addr, // Programming address
    output logic o_addr_stable, // Address settled
    output logic [7:0] o_port1_out, // Data port drive value
    output logic o_port1_oe, // Data port output enable
    output logic [7:0] o_eprom_wdata, // Byte to program
    output logic o_eprom_wr, // One-cycle write strobe
    output logic [7:0] o_port_latch // Port output latch
);

    localparam int SETTLE_W = $clog2(LOW_SETTLE_CYCLES + 1);
    localparam int VERIFY_W = $clog2(VERIFY_DELAY_CYCLES + 1);

    reset_event_t ev; // Events from the pin monitor
    pin_bus_t pins_meta; // First synchroniser stage
    pin_bus_t pins; // Synchronised pins
    mode_t mode; // Current operating mode
    mode_t next_mode;
    logic [NUM_IRQ-1:0] irq_req; // Enabled pending interrupts
    logic [2:0] top_irq; // Winning interrupt index
    logic can_take; // An interrupt may be vectored now
    logic [7:0] next_power_control_register;
    logic [ADDR_BITS-1:0] next_vector_addr;
    logic next_vector_valid;
    logic [7:0] next_port_latch;
    logic prev_address_byte_select; // Select pin one cycle ago
    logic prev_pgm_n; // Program pulse pin one cycle ago
    logic [ADDR_HI_BITS-1:0] hi_shadow; // High bits while select is high
    logic [ADDR_HI_BITS-1:0] next_hi_shadow;
    logic [SETTLE_W-1:0] settle_cnt; // Cycles the low byte held still
    logic [SETTLE_W-1:0] next_settle_cnt;
    logic [VERIFY_W-1:0] verify_cnt; // Cycles since verify started
    logic [VERIFY_W-1:0] next_verify_cnt;
    logic [ADDR_BITS-1:0] next_eprom_addr;
    logic next_addr_stable;
    logic [7:0] next_port1_out;
    logic next_port1_oe;
    logic [7:0] next_eprom_wdata;
    logic next_eprom_wr;

    // Vector address of each interrupt source
    function automatic logic [ADDR_BITS-1:0] vector_of(input logic [2:0] idx);
        logic [ADDR_BITS-1:0] v;
        v = VEC_SERIAL;
        unique case (idx)
            3'(IRQ_EXT_A): v = VEC_EXT_A;
            3'(IRQ_TIMER0): v = VEC_TIMER0;
            3'(IRQ_EXT_B): v = VEC_EXT_B;
            3'(IRQ_WDOG): v = VEC_WDOG;
            default: v = VEC_SERIAL;
        endcase
        return v;
    endfunction

    // Reset pin detector and entry code receiver
    reset_pin_monitor #(
        .ENTRY_CODE(ENTRY_CODE)
    ) u_monitor (
        .i_ref_clk(i_ref_clk),
        .i_rst_n(i_rst_n),
        .i_reset_pin(i_reset_pin),
        .o_event(ev)
    );

    // Two-stage synchroniser for programming pins
    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rst_n)
        begin
            pins_meta <= '0;
            pins <= '0;
        end
        else
        begin
            pins_meta <= {i_address_select_pin, i_port3, i_prog_pulse_n, i_vpp_high, i_port1};
            pins <= pins_meta;
        end
    end

    // Fixed priority: lowest index wins
    always_comb
    begin
        irq_req = i_irq_pending & i_irq_enable;
        top_irq = 3'(NUM_IRQ - 1);
        for (int i = NUM_IRQ - 1; i >= 0; i--)
        begin
            if (irq_req[i])
                top_irq = 3'(i);
        end
        can_take = (mode == MODE_RUN || mode == MODE_IDLE) && (|irq_req) && !o_vector_valid;
    end

    // Mode sequencing, power control and port latch
    always_comb
    begin
        next_mode = mode;
        next_power_control_register = o_power_control_register;
        next_vector_addr = o_vector_addr;
        next_vector_valid = 1'b0;
        next_port_latch = o_port_latch;
        unique case (mode)
            MODE_RESET:
            begin
                // Clear state, then start at the reset vector
                next_power_control_register = POWER_CONTROL_REGISTER_RESET;
                next_port_latch = PORT_LATCH_RESET;
                next_mode = MODE_RUN;
                next_vector_addr = VEC_RESET;
                next_vector_valid = 1'b1;
            end
            MODE_RUN:
            begin
                if (ev.enter_prog)
                    next_mode = MODE_PROG;
                else
                begin
                    if (i_power_control_register_wr)
                        next_power_control_register = i_power_control_register_wdata;
                    if (i_port_wr)
                        next_port_latch = i_port_wdata;
                    // Power-down wins over idle when both bits are set
                    if (i_instr_done && o_power_control_register[POWER_CONTROL_REGISTER_PDOWN_BIT])
                        next_mode = MODE_PDOWN;
                    else if (i_instr_done && o_power_control_register[POWER_CONTROL_REGISTER_IDLE_BIT])
                        next_mode = MODE_IDLE;
                    if (can_take)
                    begin
                        next_vector_addr = vector_of(top_irq);
                        next_vector_valid = 1'b1;
                    end
                end
            end
            MODE_IDLE:
            begin
                // Everything else stays put while idle
                if (can_take)
                begin
                    next_mode = MODE_RUN;
                    next_power_control_register[POWER_CONTROL_REGISTER_IDLE_BIT] = 1'b0;
                    next_vector_addr = vector_of(top_irq);
                    next_vector_valid = 1'b1;
                end
            end
            MODE_PDOWN:
            begin
                next_mode = MODE_PDOWN;
            end
            MODE_PROG:
            begin
                next_mode = MODE_PROG;
            end
            default:
            begin
                next_mode = MODE_RESET;
            end
        endcase
        // Hardware reset overrides every mode
        if (ev.sys_reset)
        begin
            next_mode = MODE_RESET;
            next_vector_valid = 1'b0;
        end
    end

    // Programming address and data port
    always_comb
    begin
        next_hi_shadow = hi_shadow;
        next_settle_cnt = '0;
        next_verify_cnt = '0;
        next_eprom_addr = o_eprom_addr;
        next_port1_out = o_port1_out;
        next_port1_oe = 1'b0;
        next_eprom_wdata = o_eprom_wdata;
        next_eprom_wr = 1'b0;
        if (mode != MODE_PROG)
        begin
            next_hi_shadow = '0;
            next_eprom_addr = '0;
            next_port1_out = '0;
            next_eprom_wdata = '0;
        end
        else
        begin
            if (pins.address_byte_select)
                next_hi_shadow = pins.port3[ADDR_HI_BITS-1:0];
            else
            begin
                // Falling select latches the high bits
                if (prev_address_byte_select)
                    next_eprom_addr[ADDR_BITS-1:ADDR_LO_BITS] = hi_shadow;
                next_eprom_addr[ADDR_LO_BITS-1:0] = pins.port3;
                if (!prev_address_byte_select && pins.port3 == o_eprom_addr[ADDR_LO_BITS-1:0])
                begin
                    if (settle_cnt == SETTLE_W'(LOW_SETTLE_CYCLES))
                        next_settle_cnt = settle_cnt;
                    else
                        next_settle_cnt = settle_cnt + 1'b1;
                end
            end
            if (pins.vpp_high)
            begin
                // Programming: port is an input, low pulses write
                next_eprom_wdata = pins.port1;
                next_eprom_wr = prev_pgm_n && !pins.prog_pulse_n;
            end
            else if (next_settle_cnt == SETTLE_W'(LOW_SETTLE_CYCLES))
            begin
                // Verify: drive memory contents once access time passed
                if (verify_cnt == VERIFY_W'(VERIFY_DELAY_CYCLES))
                    next_verify_cnt = verify_cnt;
                else
                    next_verify_cnt = verify_cnt + 1'b1;
                next_port1_out = i_eprom_rdata;
                next_port1_oe = pins.prog_pulse_n &&
                    (next_verify_cnt == VERIFY_W'(VERIFY_DELAY_CYCLES));
            end
        end
        next_addr_stable = (next_settle_cnt == SETTLE_W'(LOW_SETTLE_CYCLES));
    end

    // State and output registers
    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rst_n)
        begin
            mode <= MODE_RESET;
            o_machine_clk <= 1'b0;
            o_cpu_reset <= 1'b1;
            o_cpu_run <= 1'b0;
            o_periph_run <= 1'b0;
            o_osc_enable <= 1'b1;
            o_prog_state <= 1'b0;
            o_power_control_register <= POWER_CONTROL_REGISTER_RESET;
            o_vector_addr <= VEC_RESET;
            o_vector_valid <= 1'b0;
            o_port_latch <= PORT_LATCH_RESET;
            prev_address_byte_select <= 1'b0;
            prev_pgm_n <= 1'b1;
            hi_shadow <= '0;
            settle_cnt <= '0;
            verify_cnt <= '0;
            o_eprom_addr <= '0;
            o_addr_stable <= 1'b0;
            o_port1_out <= '0;
            o_port1_oe <= 1'b0;
            o_eprom_wdata <= '0;
            o_eprom_wr <= 1'b0;
        end
        else
        begin
            mode <= next_mode;
            // Divider halts only while the oscillator is stopped
            o_machine_clk <= (mode == MODE_PDOWN) ? o_machine_clk : !o_machine_clk;
            o_cpu_reset <= (next_mode == MODE_RESET);
            o_cpu_run <= (next_mode == MODE_RUN);
            o_periph_run <= (next_mode == MODE_RUN) || (next_mode == MODE_IDLE);
            o_osc_enable <= (next_mode != MODE_PDOWN);
            o_prog_state <= (next_mode == MODE_PROG);
            o_power_control_register <= next_power_control_register;
            o_vector_addr <= next_vector_addr;
            o_vector_valid <= next_vector_valid;
            o_port_latch <= next_port_latch;
            prev_address_byte_select <= pins.address_byte_select;
            prev_pgm_n <= pins.prog_pulse_n;
            hi_shadow <= next_hi_shadow;
            settle_cnt <= next_settle_cnt;
            verify_cnt <= next_verify_cnt;
            o_eprom_addr <= next_eprom_addr;
            o_addr_stable <= next_addr_stable;
            o_port1_out <= next_port1_out;
            o_port1_oe <= next_port1_oe;
            o_eprom_wdata <= next_eprom_wdata;
            o_eprom_wr <= next_eprom_wr;
        end
    end

    default clocking main_cb @(posedge i_ref_clk);
    endclocking
    default disable iff (!i_rst_n);

    reset_entry_a: assert property (ev.sys_reset |=> mode == MODE_RESET && o_cpu_reset)
        else $error("reset did not take effect");
    clock_divide_a: assert property (i_rst_n && mode != MODE_PDOWN
        |=> o_machine_clk != $past(o_machine_clk))
        else $error("divider failed to toggle");
    idle_halt_a: assert property (mode == MODE_IDLE |-> !o_cpu_run && o_periph_run)
        else $error("idle does not halt only the processor");
    idle_keep_a: assert property (mode == MODE_IDLE && !can_take && !ev.sys_reset
        |=> $stable(o_power_control_register) && $stable(o_port_latch) && mode == MODE_IDLE)
        else $error("idle changed held state");
    idle_wake_a: assert property (mode == MODE_IDLE && can_take && !ev.sys_reset
        |=> mode == MODE_RUN && o_vector_valid) else $error("interrupt missed idle exit");
    pdown_enter_a: assert property (mode == MODE_RUN && i_instr_done && !ev.sys_reset &&
        !ev.enter_prog && o_power_control_register[POWER_CONTROL_REGISTER_PDOWN_BIT]
        |=> mode == MODE_PDOWN && !o_osc_enable) else $error("power-down not entered");
    pdown_stay_a: assert property (mode == MODE_PDOWN && !ev.sys_reset
        |=> mode == MODE_PDOWN && !o_vector_valid) else $error("power-down left");
    reset_vector_a: assert property (i_rst_n && mode == MODE_RESET && !ev.sys_reset
        |=> o_vector_valid && o_vector_addr == VEC_RESET) else $error("bad reset vector");
    prio_order_a: assert property (can_take && !ev.sys_reset && irq_req[IRQ_EXT_A] &&
        mode == MODE_RUN && !ev.enter_prog |=> o_vector_addr == VEC_EXT_A)
        else $error("priority order broken");
    port_hold_a: assert property ((mode == MODE_IDLE || mode == MODE_PDOWN)
        |=> $stable(o_port_latch)) else $error("port latch changed in low power");
    hi_latch_a: assert property (mode == MODE_PROG && !pins.address_byte_select && prev_address_byte_select
        |=> o_eprom_addr[ADDR_BITS-1:ADDR_LO_BITS] == $past(hi_shadow))
        else $error("high address not latched");
    prog_input_a: assert property (mode == MODE_PROG && pins.vpp_high
        |=> !o_port1_oe && o_eprom_wdata == $past(pins.port1))
        else $error("data port not an input in programming");

    idle_wake_c: cover property (mode == MODE_IDLE ##1 mode == MODE_RUN);
    pdown_reset_c: cover property (mode == MODE_PDOWN ##1 mode == MODE_RESET);
    prog_entry_c: cover property (mode == MODE_RUN ##1 mode == MODE_PROG);
    verify_drive_c: cover property (o_port1_oe && o_addr_stable);

endmodule

// ---- prog_model.sv ----
`timescale 1ns/1ps

module prog_model
(
    input wire logic i_ref_clk, // Oscillator clock
    output logic o_reset_pin, // Reset and code pin
    output logic o_select, // Address byte select
    output logic [7:0] o_port3 // Address port
);
    initial {o_reset_pin, o_select, o_port3} = '0;
    // Hold the pin high n clocks, then low for the restart
    task automatic pulse(input int n);
        o_reset_pin <= 1'b1;
        repeat (n) @(posedge i_ref_clk);
        o_reset_pin <= 1'b0;
        repeat (8) @(posedge i_ref_clk);
    endtask
    // Shift the code low bit first, changing the pin only while the clock is low
    task automatic code(input logic [9:0] c);
        for (int b = 0; b < 10; b++)
        begin
            @(negedge i_ref_clk);
            o_reset_pin <= c[b];
            @(posedge i_ref_clk);
        end
        @(negedge i_ref_clk);
        o_reset_pin <= 1'b0;
    endtask
    // High bits with junk above them, then the low byte
    task automatic addr(input logic [10:0] a, input logic [4:0] j);
        {o_select, o_port3} <= {1'b1, j, a[10:8]};
        repeat (14) @(posedge i_ref_clk);
        o_select <= 1'b0;
        repeat (2) @(posedge i_ref_clk);
        o_port3 <= a[7:0];
    endtask
endmodule

// ---- reset_power_mode_control_tb.sv ----
`timescale 1ns/1ps

module reset_power_mode_control_tb;
    import rpmc_pkg::*;
    logic clk, rst_n, rpin, sel, vpp, pw, pd, ww, sr, run, per, osc, prog, stab, oe, vv;
    logic cr, mck, mc, wr, pg, clr;
    logic [7:0] p3, p1, rdata, wd, power_control_register, latch, ewd, p1o, pl;
    logic [NUM_IRQ-1:0] pend, m, en;
    logic [10:0] va, eaddr;
    logic [10:0] lv; // Last vector taken
    logic [31:0] r;
    logic [31:0] seed = 32'hC; // Fixed seed
    int mismatches = 0;
    int total_checks = 0;
    int nw = 0; // Write strobes seen
    logic [10:0] vt [5] = '{VEC_EXT_A, VEC_TIMER0, VEC_EXT_B, VEC_WDOG, VEC_SERIAL};
    prog_model prog_model_i (.i_ref_clk(clk), .o_reset_pin(rpin), .o_select(sel), .o_port3(p3));
    reset_power_mode_control reset_power_mode_control_i (.i_ref_clk(clk), .i_rst_n(rst_n),
        .i_reset_pin(rpin), .i_address_select_pin(sel), .i_port3(p3), .i_prog_pulse_n(pg),
        .i_vpp_high(vpp), .i_port1(p1), .i_eprom_rdata(rdata), .i_power_control_register_wr(pw),
        .i_power_control_register_wdata(wd), .i_instr_done(pd), .i_irq_pending(pend), .i_irq_enable(en),
        .i_port_wr(ww), .i_port_wdata(wd), .o_machine_clk(mck), .o_cpu_reset(cr),
        .o_cpu_run(run), .o_periph_run(per), .o_osc_enable(osc), .o_prog_state(prog),
        .o_power_control_register(power_control_register), .o_vector_addr(va), .o_vector_valid(vv),
        .o_eprom_addr(eaddr), .o_addr_stable(stab), .o_port1_out(p1o), .o_port1_oe(oe),
        .o_eprom_wdata(ewd), .o_eprom_wr(wr), .o_port_latch(latch));
    // Clock, 100 ns period
    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // Sticky reset flag, last vector seen and write strobe count
    always @(posedge clk)
    begin
        sr <= cr | (sr & !clr);
        if (vv) lv <= va;
        else if (clr) lv <= 11'h7FF;
        if (wr) nw <= nw + 1;
    end
    // Xorshift source
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic chk(input logic [10:0] g, input logic [10:0] e);
        total_checks++;
        if (g !== e)
        begin
            mismatches++;
            $display("[ERR] %0t got %h expected %h", $time, g, e);
        end
    endtask
    // Write the mode byte, then end the instruction
    task automatic pwr(input logic [7:0] v);
        @(posedge clk) {pw, wd} <= {1'b1, v};
        @(posedge clk) {pw, pd} <= 2'b01;
        @(posedge clk) pd <= 1'b0;
        repeat (3) @(posedge clk);
        @(negedge clk);
    endtask
    task automatic report_and_stop;
        if (mismatches == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // Cut a hang short
    initial
    begin
        repeat (3000) @(posedge clk);
        mismatches++;
        report_and_stop;
    end
    initial
    begin
        {rst_n, vpp, p1, rdata, pw, pd, pend, ww, wd, en, clr} = '0;
        pg = 1'b1;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        @(negedge clk);
        chk(lv, VEC_RESET);
        chk(latch, PORT_LATCH_RESET);
        mc = mck;
        @(negedge clk);
        chk(mck, !mc);
        clr <= 1'b1;
        @(posedge clk) clr <= 1'b0;
        prog_model_i.pulse(23);
        @(negedge clk);
        chk(sr, 1'b0);
        @(posedge clk) prog_model_i.pulse(24);
        @(negedge clk);
        chk(sr, 1'b1);
        r = rnd();
        pl = r[7:0];
        @(posedge clk) {ww, wd} <= {1'b1, pl};
        @(posedge clk) ww <= 1'b0;
        // Wake from idle by each source with lower ones masked off
        for (int k = 0; k < NUM_IRQ; k++)
        begin
            pwr(8'h01);
            chk(run, 1'b0);
            chk(per, 1'b1);
            chk(power_control_register, 8'h01);
            r = rnd();
            m = 5'h01 << k;
            clr <= 1'b1;
            @(posedge clk) {pend, en, clr} <= {r[4:0] | m, ~(m - 5'h01), 1'b0};
            repeat (3) @(posedge clk);
            pend <= '0;
            @(negedge clk);
            chk(lv, vt[k]);
            chk(run, 1'b1);
            chk(latch, pl);
        end
        chk(latch, pl);
        pwr(8'h02);
        chk(osc, 1'b0);
        mc = mck;
        @(posedge clk) pend <= 5'h1F;
        repeat (6) @(posedge clk);
        pend <= '0;
        @(negedge clk);
        chk(osc, 1'b0);
        chk(mck, mc);
        @(posedge clk) prog_model_i.pulse(24);
        @(negedge clk);
        chk(osc, 1'b1);
        @(posedge clk) prog_model_i.code(~ENTRY_CODE_DEFAULT);
        repeat (6) @(posedge clk);
        @(negedge clk);
        chk(prog, 1'b0);
        @(posedge clk) prog_model_i.code(ENTRY_CODE_DEFAULT);
        repeat (6) @(posedge clk);
        @(negedge clk);
        chk(prog, 1'b1);
        r = rnd();
        @(posedge clk) prog_model_i.addr(r[10:0], r[15:11]);
        repeat (18) @(posedge clk);
        @(negedge clk);
        chk(eaddr, r[10:0]);
        chk(stab, 1'b1);
        @(posedge clk) {vpp, p1, rdata} <= {1'b1, r[23:8]};
        repeat (4) @(posedge clk);
        @(negedge clk);
        chk(ewd, r[23:16]);
        chk(oe, 1'b0);
        @(posedge clk) pg <= 1'b0;
        repeat (3) @(posedge clk);
        pg <= 1'b1;
        repeat (4) @(posedge clk);
        @(negedge clk);
        chk(11'(nw), 11'h001);
        @(posedge clk) vpp <= 1'b0;
        repeat (VERIFY_DELAY_CYCLES + 6) @(posedge clk);
        @(negedge clk);
        chk(oe, 1'b1);
        chk(p1o, r[15:8]);
        report_and_stop;
    end
endmodule
